// File: spch_pkg.sv
// Constants and types shared by the security command handler
package spch_pkg;
    // Operation codes and descriptor fields
    localparam logic [7:0] OPC_RECV = 8'hA2;
    localparam logic [7:0] OPC_SEND = 8'hB5;
    localparam int INC_BIT = 7;
    localparam int LEN_W = 32;
    localparam int UNIT_SHIFT = 9;
    localparam int CNT_W = LEN_W + UNIT_SHIFT;
    // Protocol selector codes
    localparam logic [7:0] PROTO_INFO = 8'h00;
    localparam logic [7:0] PROTO_FIRST = 8'h01;
    localparam logic [7:0] PROTO_LAST = 8'h06;
    localparam logic [7:0] PAD_BYTE = 8'h00;
    // Supported-protocol list: header bytes, list length, total length
    localparam logic [7:0] INFO_HDR = 8'h08;
    localparam logic [7:0] INFO_LIST_LEN = 8'h07;
    localparam logic [CNT_W-1:0] INFO_LEN = 41'h0000000000F;
    // Status and sense values
    localparam logic [7:0] STS_GOOD = 8'h00;
    localparam logic [7:0] STS_CHECK = 8'h02;
    localparam logic [3:0] SK_NONE = 4'h0;
    localparam logic [3:0] SK_ILLEGAL = 4'h5;
    localparam logic [3:0] SK_ABORTED = 4'hB;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_INV_OPC = 8'h20;
    localparam logic [7:0] ASC_INV_FIELD = 8'h24;
    localparam logic [7:0] ASC_SEQ_ERR = 8'h2C;

    // Twelve-byte command descriptor, byte 0 in the top bits
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] proto;
        logic [15:0] spec;
        logic [7:0] flags;
        logic [7:0] rsvd5;
        logic [LEN_W-1:0] len;
        logic [7:0] rsvd10;
        logic [7:0] control;
    } spch_cdb_s;

    // Initiator port and logical unit of a command
    typedef struct packed {
        logic [7:0] it_id;
        logic [7:0] lun;
    } spch_nexus_s;

    // Completion status with sense data
    typedef struct packed {
        logic [7:0] status;
        logic [3:0] key;
        logic [7:0] asc;
    } spch_sts_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SEND = 4'h2,
        ST_WAIT = 4'h4,
        ST_RECV = 4'h8
    } spch_state_e;
endpackage

// File: spch_fifo.sv
// Result byte FIFO with registered full and empty flags
`timescale 1ns/10ps
module spch_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic clr_i,
    // Filling side
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    // Draining side
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    // Pointers carry one extra bit to tell full from empty
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic full;
        logic empty;
    } spch_fifo_s;

    spch_fifo_s r;
    spch_fifo_s n;

    // Depth must be a power of two of at least two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("spch_fifo: DEPTH must be a power of two >= 2");
    end

    // Next state of storage and pointers
    always_comb begin
        n = r;
        if (in_valid_i && !r.full) begin
            n.mem[r.wp[AW-1:0]] = in_data_i;
            n.wp = r.wp + 1'b1;
        end
        if (out_ready_i && !r.empty) begin
            n.rp = r.rp + 1'b1;
        end
        if (clr_i) begin
            n.wp = '0;
            n.rp = '0;
        end
        n.empty = (n.wp == n.rp);
        n.full = (n.wp[AW] != n.rp[AW]) && (n.wp[AW-1:0] == n.rp[AW-1:0]);
    end

    // State register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '{mem: '0, wp: '0, rp: '0, full: 1'b0, empty: 1'b1};
        end else begin
            r <= n;
        end
    end

    // Flags and head word come straight from the register
    assign in_ready_o = !r.full;
    assign out_valid_o = !r.empty;
    assign out_data_o = r.mem[r.rp[AW-1:0]];
endmodule

// File: spch_handler.sv
// Security protocol send and read-back command handler
`timescale 1ns/10ps
module spch_handler
    import spch_pkg::*;
#(
    parameter logic [6:0] SYNC_MASK = 7'h00,
    parameter int RES_DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Command descriptor
    input wire logic cmd_valid_i,
    input wire spch_pkg::spch_cdb_s cmd_cdb_i,
    input wire spch_pkg::spch_nexus_s cmd_nexus_i,
    output logic cmd_ready_o,
    // Send payload from host
    input wire logic dout_valid_i,
    input wire logic [7:0] dout_data_i,
    output logic dout_ready_o,
    // Read-back data to host
    output logic din_valid_o,
    output logic [7:0] din_data_o,
    input wire logic din_ready_i,
    // Protocol engine
    output logic eng_valid_o,
    output logic [7:0] eng_data_o,
    output logic [7:0] eng_proto_o,
    output logic [15:0] eng_spec_o,
    input wire logic eng_ready_i,
    input wire logic eng_done_i,
    input wire logic eng_ok_i,
    input wire logic res_valid_i,
    input wire logic [7:0] res_data_i,
    output logic res_ready_o,
    // Reset and nexus events
    input wire logic lu_reset_i,
    input wire logic it_loss_i,
    input wire logic [7:0] it_loss_id_i,
    // Completion
    output logic sts_valid_o,
    output spch_pkg::spch_sts_s sts_o,
    output logic res_held_o
);
    typedef struct packed {
        spch_state_e st;
        logic cmd_rdy;
        logic rx_rdy;
        logic eng_vld;
        logic [7:0] eng_dat;
        logic tx_vld;
        logic [7:0] tx_dat;
        logic sts_vld;
        spch_sts_s sts;
        logic [7:0] proto;
        logic [15:0] spec;
        logic inc;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] idx;
        logic held;
        spch_nexus_s owner;
        spch_nexus_s cur;
        logic clr;
    } spch_regs_s;

    spch_regs_s r;
    spch_regs_s n;
    logic fifo_vld;
    logic [7:0] fifo_dat;
    logic fifo_rd;
    logic flush;
    logic is_info;
    logic mine;
    logic src_ok;
    logic pad;
    logic load;
    logic [7:0] src_dat;
    logic [7:0] info_byte;
    logic [CNT_W-1:0] len_bytes;

    // Result storage between engine and read-back
    spch_fifo #(.W(8), .DEPTH(RES_DEPTH)) u_res_fifo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .clr_i(r.clr),
        .in_valid_i(res_valid_i),
        .in_data_i(res_data_i),
        .in_ready_o(res_ready_o),
        .out_valid_o(fifo_vld),
        .out_data_o(fifo_dat),
        .out_ready_i(fifo_rd)
    );

    // Supported-protocol list: header zeros, list length, then codes
    always_comb begin
        if (r.idx[7:0] < INFO_HDR) begin
            info_byte = (r.idx[7:0] == INFO_HDR - 8'h01) ? INFO_LIST_LEN : 8'h00;
        end else begin
            info_byte = r.idx[7:0] - INFO_HDR;
        end
    end

    // Read-back byte source selection
    always_comb begin
        len_bytes = cmd_cdb_i.flags[INC_BIT] ? {cmd_cdb_i.len, {UNIT_SHIFT{1'b0}}}
                                             : {{UNIT_SHIFT{1'b0}}, cmd_cdb_i.len};
        flush = lu_reset_i || (it_loss_i && r.held && it_loss_id_i == r.owner.it_id);
        is_info = (r.proto == PROTO_INFO);
        mine = r.held && (r.owner == r.cur);
        src_ok = is_info ? (r.idx < INFO_LEN) : (mine && fifo_vld);
        src_dat = is_info ? info_byte : fifo_dat;
        pad = r.inc && (r.idx[UNIT_SHIFT-1:0] != '0) && !src_ok;
        load = (r.st == ST_RECV) && (!r.tx_vld || din_ready_i) && (r.cnt != '0)
               && (src_ok || pad);
        fifo_rd = load && src_ok && !is_info;
    end

    // Command sequencing
    always_comb begin
        n = r;
        n.sts_vld = 1'b0;
        n.clr = 1'b0;
        if (flush) begin
            n.held = 1'b0;
            n.clr = 1'b1;
        end
        case (r.st)
            ST_IDLE: begin
                if (cmd_valid_i) begin
                    n.proto = cmd_cdb_i.proto;
                    n.spec = cmd_cdb_i.spec;
                    n.inc = cmd_cdb_i.flags[INC_BIT];
                    n.cur = cmd_nexus_i;
                    n.cnt = len_bytes;
                    n.idx = '0;
                    n.sts_vld = 1'b1;
                    n.sts = '{STS_CHECK, SK_ILLEGAL, ASC_INV_FIELD};
                    if (cmd_cdb_i.opcode == OPC_RECV) begin
                        if (cmd_cdb_i.proto <= PROTO_LAST) begin
                            n.sts_vld = 1'b0;
                            n.st = ST_RECV;
                        end
                    end else if (cmd_cdb_i.opcode == OPC_SEND) begin
                        if (cmd_cdb_i.proto < PROTO_FIRST || cmd_cdb_i.proto > PROTO_LAST) begin
                            n.sts = '{STS_CHECK, SK_ILLEGAL, ASC_INV_FIELD};
                        end else if (r.held && !flush && r.owner != cmd_nexus_i) begin
                            n.sts = '{STS_CHECK, SK_ILLEGAL, ASC_SEQ_ERR};
                        end else begin
                            n.sts_vld = 1'b0;
                            n.st = ST_SEND;
                            n.owner = cmd_nexus_i;
                            n.held = 1'b1;
                            n.clr = 1'b1;
                            n.rx_rdy = (len_bytes != '0);
                        end
                    end else begin
                        n.sts = '{STS_CHECK, SK_ILLEGAL, ASC_INV_OPC};
                    end
                end
            end
            ST_SEND: begin
                if (dout_valid_i && r.rx_rdy) begin
                    n.eng_vld = 1'b1;
                    n.eng_dat = dout_data_i;
                    n.cnt = r.cnt - 1'b1;
                    n.rx_rdy = 1'b0;
                end
                if (r.eng_vld && eng_ready_i) begin
                    n.eng_vld = 1'b0;
                    n.rx_rdy = (r.cnt != '0);
                end
                if (!r.eng_vld && !r.rx_rdy && r.cnt == '0) begin
                    if (SYNC_MASK[r.proto[2:0]]) begin
                        n.st = ST_WAIT;
                    end else begin
                        n.st = ST_IDLE;
                        n.sts_vld = 1'b1;
                        n.sts = '{STS_GOOD, SK_NONE, ASC_NONE};
                    end
                end
            end
            ST_WAIT: begin
                if (eng_done_i) begin
                    n.st = ST_IDLE;
                    n.sts_vld = 1'b1;
                    n.sts = eng_ok_i ? '{STS_GOOD, SK_NONE, ASC_NONE}
                                     : '{STS_CHECK, SK_ABORTED, ASC_NONE};
                end
            end
            ST_RECV: begin
                if (r.tx_vld && din_ready_i) begin
                    n.tx_vld = 1'b0;
                end
                if (load) begin
                    n.tx_vld = 1'b1;
                    n.tx_dat = src_ok ? src_dat : PAD_BYTE;
                    n.cnt = r.cnt - 1'b1;
                    n.idx = r.idx + 1'b1;
                end else if (!r.tx_vld) begin
                    n.st = ST_IDLE;
                    n.sts_vld = 1'b1;
                    n.sts = '{STS_GOOD, SK_NONE, ASC_NONE};
                    // Only a read that actually took results releases them
                    if (!is_info && mine && !fifo_vld && r.idx != '0) begin
                        n.held = 1'b0;
                    end
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase
        n.cmd_rdy = (n.st == ST_IDLE);
    end

    // State register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '{st: ST_IDLE, cmd_rdy: 1'b1, sts: '{STS_GOOD, SK_NONE, ASC_NONE},
                   owner: '0, cur: '0, default: '0};
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the register
    assign cmd_ready_o = r.cmd_rdy;
    assign dout_ready_o = r.rx_rdy;
    assign din_valid_o = r.tx_vld;
    assign din_data_o = r.tx_dat;
    assign eng_valid_o = r.eng_vld;
    assign eng_data_o = r.eng_dat;
    assign eng_proto_o = r.proto;
    assign eng_spec_o = r.spec;
    assign sts_valid_o = r.sts_vld;
    assign sts_o = r.sts;
    assign res_held_o = r.held;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_cmd(logic [7:0] opc);
        r.st == ST_IDLE && cmd_valid_i && cmd_cdb_i.opcode == opc;
    endsequence

    sequence s_send_done;
        r.st == ST_SEND && r.cnt == '0 && !r.eng_vld && !r.rx_rdy && !SYNC_MASK[r.proto[2:0]];
    endsequence

    sequence s_good_idle;
        sts_valid_o && sts_o.status == STS_GOOD && r.st == ST_IDLE;
    endsequence

    a_recv_reserved_chk: assert property (
        s_cmd(OPC_RECV) ##0 cmd_cdb_i.proto > PROTO_LAST
        |=> sts_valid_o && sts_o.status == STS_CHECK && sts_o.asc == ASC_INV_FIELD
            && r.st == ST_IDLE && !din_valid_o) else $error("reserved read-back not rejected");
    a_send_zero_chk: assert property (s_cmd(OPC_SEND) ##0 cmd_cdb_i.proto == PROTO_INFO
        |=> sts_valid_o && sts_o.key == SK_ILLEGAL && !dout_ready_o)
        else $error("send selector zero not rejected");
    a_recv_scaled_len: assert property (
        s_cmd(OPC_RECV) ##0 cmd_cdb_i.proto <= PROTO_LAST
        ##0 cmd_cdb_i.flags[INC_BIT] |=> r.cnt == $past(len_bytes) && r.cnt[UNIT_SHIFT-1:0] == '0)
        else $error("scaled length wrong");
    a_send_byte_len: assert property (s_cmd(OPC_SEND) ##0 !cmd_cdb_i.flags[INC_BIT]
        ##0 r.st == ST_IDLE |=> r.st != ST_SEND || r.cnt == CNT_W'($past(cmd_cdb_i.len)))
        else $error("byte length wrong");
    a_pad_zero_byte: assert property (
        load && !src_ok |=> din_valid_o && din_data_o == PAD_BYTE)
        else $error("pad byte not zero");
    a_info_list_len: assert property (load && is_info && r.idx == CNT_W'(7)
        |=> din_data_o == INFO_LIST_LEN) else $error("protocol list length wrong");
    a_hold_results: assert property (r.held && !flush && r.st != ST_RECV |=> r.held)
        else $error("results dropped early");
    // A send taken in the flush cycle sets the hold again, so it is left out
    a_flush_results: assert property (
        lu_reset_i && !(r.st == ST_IDLE && cmd_valid_i && cmd_cdb_i.opcode == OPC_SEND)
        |=> !res_held_o ##1 !fifo_vld || $past(res_valid_i))
        else $error("unit reset kept results");
    a_good_on_rx: assert property (s_send_done |=> s_good_idle)
        else $error("no good status after receipt");
    a_good_after_proc: assert property (
        r.st == ST_WAIT && eng_done_i && eng_ok_i |=> s_good_idle)
        else $error("no good status after processing");
    a_nodata_ends: assert property (
        r.st == ST_RECV && !r.tx_vld && !load |=> s_good_idle)
        else $error("empty read-back did not end");
endmodule

// File: spch_engine_model.sv
// Protocol engine model: takes payload bytes and offers result bytes
`timescale 1ns/10ps
module spch_engine_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic echo_i,
    // Payload from the handler
    input wire logic eng_valid_i,
    input wire logic [7:0] eng_data_i,
    output logic eng_ready_o,
    output logic [15:0] taken_o,
    // Results to the handler
    output logic res_valid_o,
    output logic [7:0] res_data_o,
    input wire logic res_ready_i
);
    logic [7:0] res_q[$];

    // Ready alternates so the handler meets both a stall and a prompt take
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            eng_ready_o <= 1'b0;
            taken_o <= 16'h0000;
            res_valid_o <= 1'b0;
            res_data_o <= 8'h00;
            res_q.delete();
        end else begin
            if (res_valid_o && res_ready_i) void'(res_q.pop_front());
            if (eng_valid_i && eng_ready_o) begin
                taken_o <= taken_o + 16'h0001;
                if (echo_i) res_q.push_back(eng_data_i ^ 8'h5A);
            end
            eng_ready_o <= ~eng_ready_o;
            res_valid_o <= (res_q.size() != 0);
            // Idle data keeps changing so a stale byte is never mistaken for a result
            res_data_o <= (res_q.size() != 0) ? res_q[0] : ~res_data_o;
        end
    end
endmodule

// File: tb_top.sv
// Self-checking testbench for the security command handler
`timescale 1ns/10ps
module tb_top;
    import spch_pkg::*;
    localparam logic [19:0] OK_STS = {STS_GOOD, SK_NONE, ASC_NONE};
    logic clk_i, arst_n_i, cmd_valid_i, cmd_ready_o, dout_valid_i, dout_ready_o;
    logic din_valid_o, din_ready_i, eng_valid_o, eng_ready_i, eng_done_i, eng_ok_i;
    logic res_valid_i, res_ready_o, lu_reset_i, it_loss_i, sts_valid_o, res_held_o, echo;
    logic [7:0] dout_data_i, din_data_o, eng_data_o, eng_proto_o, res_data_i, it_loss_id_i;
    logic [15:0] eng_spec_o, taken;
    spch_cdb_s cmd_cdb_i;
    spch_nexus_s cmd_nexus_i;
    spch_sts_s sts_o, sts_seen;
    logic [7:0] tx_q[$], rx_q[$], exp_q[$];
    int fails, check_count, done_k, k_end;

    spch_handler #(.SYNC_MASK(7'h04), .RES_DEPTH(16)) dut_u (.clk_i, .arst_n_i, .cmd_valid_i,
        .cmd_cdb_i, .cmd_nexus_i, .cmd_ready_o, .dout_valid_i, .dout_data_i, .dout_ready_o,
        .din_valid_o, .din_data_o, .din_ready_i, .eng_valid_o, .eng_data_o, .eng_proto_o,
        .eng_spec_o, .eng_ready_i, .eng_done_i, .eng_ok_i, .res_valid_i, .res_data_i,
        .res_ready_o, .lu_reset_i, .it_loss_i, .it_loss_id_i, .sts_valid_o, .sts_o, .res_held_o);
    spch_engine_model eng_u (.clk_i, .arst_n_i, .echo_i(echo), .eng_valid_i(eng_valid_o),
        .eng_data_i(eng_data_o), .eng_ready_o(eng_ready_i), .taken_o(taken),
        .res_valid_o(res_valid_i), .res_data_o(res_data_i), .res_ready_i(res_ready_o));

    // Clock at 40 MHz
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Compare one value and count it
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // Offer one command, move payload and read-back bytes until the status pulse
    task automatic xfer(input logic [7:0] opc, input logic [7:0] proto, input logic sc,
                        input logic [31:0] len, input logic [7:0] it);
        int k;
        k = 0;
        rx_q.delete();
        @(posedge clk_i);
        #1;
        cmd_cdb_i = '{opcode: opc, proto: proto, spec: 16'hC3A5, flags: {sc, 7'h00},
                      rsvd5: 8'h00, len: len, rsvd10: 8'h00, control: 8'h00};
        cmd_nexus_i = '{it_id: it, lun: 8'h00};
        cmd_valid_i = 1'b1;
        do @(posedge clk_i); while (!cmd_ready_o);
        #1;
        cmd_valid_i = 1'b0;
        while (k < 3000) begin
            dout_valid_i = (tx_q.size() != 0);
            dout_data_i = dout_valid_i ? tx_q[0] : ~dout_data_i;
            eng_done_i = (k == done_k);
            @(posedge clk_i);
            if (dout_valid_i && dout_ready_o) void'(tx_q.pop_front());
            if (din_valid_o && din_ready_i) rx_q.push_back(din_data_o);
            if (sts_valid_o) break;
            #1;
            din_ready_i = ~din_ready_i; // Host stalls every other cycle
            k++;
        end
        sts_seen = sts_o;
        k_end = k;
        if (k >= 3000) chk(0, 1, "no status");
        #1;
        dout_valid_i = 1'b0;
        eng_done_i = 1'b0;
    endtask

    // Judge status and read-back bytes against the expectation
    task automatic expect_rx(input logic [19:0] st, input string what);
        chk(sts_seen, st, what);
        chk(rx_q.size(), exp_q.size(), what);
        foreach (exp_q[i]) if (i < rx_q.size()) chk(rx_q[i], exp_q[i], what);
    endtask

    // Pulse a unit reset or a nexus loss
    task automatic evt(input logic lu, input logic [7:0] id);
        @(posedge clk_i);
        #1;
        lu_reset_i = lu;
        it_loss_i = ~lu;
        it_loss_id_i = id;
        @(posedge clk_i);
        #1;
        lu_reset_i = 1'b0;
        it_loss_i = 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic t_reset();
        chk(cmd_ready_o, 1, "ready after reset");
        chk({sts_valid_o, din_valid_o, eng_valid_o, res_held_o, sts_o}, 0, "idle outputs");
        chk(res_ready_o, 1, "fifo ready after reset");
        $display("test reset done");
    endtask

    task automatic t_reject();
        logic [23:0] tbl[5] = '{24'h120020, 24'hA20724, 24'hA2FF24, 24'hB50024, 24'hB50724};
        foreach (tbl[i]) begin
            tx_q = '{8'h11};
            exp_q.delete();
            xfer(tbl[i][23:16], tbl[i][15:8], 1'b0, 32'h4, 8'h01);
            expect_rx({STS_CHECK, SK_ILLEGAL, tbl[i][7:0]}, "reject");
            chk(tx_q.size(), 1, "reject took data");
            chk(cmd_ready_o, 1, "ready after reject");
        end
        tx_q.delete();
        $display("test reject done");
    endtask

    task automatic t_info();
        logic [7:0] lst[$];
        for (int i = 0; i < 15; i++) lst.push_back(i < 7 ? 8'h00 : (i == 7 ? 8'h07 : 8'(i - 8)));
        exp_q = lst[0:1];
        xfer(OPC_RECV, PROTO_INFO, 1'b0, 32'h2, 8'h01);
        expect_rx(OK_STS, "list cut");
        exp_q = lst;
        xfer(OPC_RECV, PROTO_INFO, 1'b0, 32'h14, 8'h01);
        expect_rx(OK_STS, "list bytes");
        while (exp_q.size() < 512) exp_q.push_back(PAD_BYTE);
        xfer(OPC_RECV, PROTO_INFO, 1'b1, 32'h1, 8'h01);
        expect_rx(OK_STS, "list padded");
        $display("test info done");
    endtask

    task automatic t_results();
        logic [7:0] res[$];
        logic [15:0] t0;
        echo = 1'b1;
        t0 = taken;
        for (int i = 0; i < 20; i++) begin
            tx_q.push_back(8'(i * 7 + 1));
            res.push_back(8'(i * 7 + 1) ^ 8'h5A);
        end
        exp_q.delete();
        xfer(OPC_SEND, 8'h01, 1'b0, 32'h14, 8'h03);
        expect_rx(OK_STS, "send");
        chk(taken - t0, 20, "payload count");
        chk({eng_proto_o, eng_spec_o}, 24'h01C3A5, "engine selector");
        chk({res_held_o, res_ready_o}, 2'b10, "held and full");
        xfer(OPC_RECV, 8'h01, 1'b0, 32'h20, 8'h04);
        expect_rx(OK_STS, "other nexus");
        chk(res_held_o, 1, "held for owner");
        exp_q = res;
        xfer(OPC_RECV, 8'h01, 1'b0, 32'h20, 8'h03);
        expect_rx(OK_STS, "owner read");
        chk(res_held_o, 0, "released after read");
        $display("test results done");
    endtask

    task automatic t_flush();
        exp_q.delete();
        tx_q = '{8'h21, 8'h22};
        xfer(OPC_SEND, 8'h01, 1'b0, 32'h2, 8'h05);
        chk(res_held_o, 1, "held");
        tx_q = '{8'h23};
        xfer(OPC_SEND, 8'h01, 1'b0, 32'h1, 8'h06);
        expect_rx({STS_CHECK, SK_ILLEGAL, ASC_SEQ_ERR}, "foreign send");
        tx_q.delete();
        evt(1'b0, 8'h06);
        chk(res_held_o, 1, "loss of other nexus");
        evt(1'b0, 8'h05);
        chk(res_held_o, 0, "loss of owner");
        tx_q = '{8'h24};
        xfer(OPC_SEND, 8'h02 - 8'h01, 1'b0, 32'h1, 8'h05);
        evt(1'b1, 8'h00);
        chk(res_held_o, 0, "unit reset");
        xfer(OPC_RECV, 8'h01, 1'b0, 32'h10, 8'h05);
        expect_rx(OK_STS, "nothing left");
        echo = 1'b0;
        $display("test flush done");
    endtask

    task automatic t_sync();
        for (int i = 0; i < 2; i++) begin
            eng_ok_i = i[0];
            done_k = 12;
            tx_q = '{8'h31};
            xfer(OPC_SEND, 8'h02, 1'b0, 32'h1, 8'h05);
            expect_rx(i ? OK_STS : {STS_CHECK, SK_ABORTED, ASC_NONE}, "sync send");
            chk(k_end, 13, "status after processing");
        end
        done_k = -1;
        $display("test sync done");
    endtask

    task automatic t_scaled();
        logic [15:0] t0;
        t0 = taken;
        tx_q = '{8'hAB, 8'hCD, 8'hEF};
        while (tx_q.size() < 512) tx_q.push_back(PAD_BYTE);
        tx_q.push_back(8'h77);
        xfer(OPC_SEND, 8'h01, 1'b1, 32'h1, 8'h05);
        expect_rx(OK_STS, "scaled send");
        chk(taken - t0, 512, "scaled count");
        chk(tx_q.size(), 1, "extra byte taken");
        tx_q.delete();
        $display("test scaled done");
    endtask

    // Print the counts and the verdict, then end the run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #(25 * 40000);
        fails++;
        stop_test();
    end

    // Main sequence
    initial begin
        {arst_n_i, cmd_valid_i, dout_valid_i, din_ready_i, eng_done_i, eng_ok_i} = '0;
        {lu_reset_i, it_loss_i, echo, dout_data_i, it_loss_id_i} = '0;
        cmd_cdb_i = '0;
        cmd_nexus_i = '0;
        fails = 0;
        check_count = 0;
        done_k = -1;
        repeat (4) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        t_reset();
        t_reject();
        t_info();
        t_results();
        t_flush();
        t_sync();
        t_scaled();
        stop_test();
    end
endmodule
